// [design/dstt_top.sv]
// Disk sector and track transfer sequencer without length checking and with it.
`timescale 1ns/100ps
`default_nettype none
`include "dstt_cfg.svh"
module dstt_top (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       cmd_valid,
	input  wire logic [7:0] cmd_op,
	input  wire logic [3:0] cmd_mod,
	input  wire logic [11:0] cmd_sectors,
	output logic            busy,
	output logic            done,
	output logic            invalid_op,
	output logic            wrong_length,
	output logic            compare_err,
	input  wire logic       disk_index_pin,
	input  wire logic       disk_rd_valid,
	input  wire logic [5:0] disk_rd_data,
	output logic            disk_rd_ready,
	output logic            disk_wr_valid,
	output logic [5:0]      disk_wr_data,
	input  wire logic       disk_wr_ready,
	input  wire logic       core_rd_valid,
	input  wire logic [5:0] core_rd_data,
	output logic            core_rd_ready,
	output logic            core_wr_valid,
	output logic [5:0]      core_wr_data,
	input  wire logic       core_wr_ready
);
	typedef struct packed {
		dstt_pkg::dstt_state_e st;
		dstt_pkg::dstt_dir_e   dir;
		logic                  track;
		logic                  chk;
		logic                  stop;
		logic                  skip;
		logic [5:0]            hold;
		logic                  idx_s1;
		logic                  idx_s2;
		logic                  idx_s3;
		logic                  busy;
		logic                  done;
		logic                  inv;
		logic                  wlr;
		logic                  cmp_err;
		logic                  disk_rd_rdy;
		logic                  disk_wr_vld;
		logic [5:0]            disk_wr_dat;
		logic                  core_rd_rdy;
		logic                  core_wr_vld;
		logic [5:0]            core_wr_dat;
	} dstt_top_s;

	dstt_top_s q;
	dstt_top_s d;
	dstt_cnt_if cnt ();
	dstt_pkg::dstt_dec_s dec;
	logic take_core;
	logic take_disk;
	logic gm_core;
	logic gm_disk;
	logic idx_rise;

	// ------------------------------------------------------------------
	// Position counter
	// ------------------------------------------------------------------
	dstt_cnt u_cnt (
		.sys_clk (sys_clk),
		.rst     (rst),
		.cnt     (cnt.cnt)
	);

	// ------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------
	// Any pairing not listed falls through to an invalid operation
	function automatic dstt_pkg::dstt_dec_s decode(input logic [7:0] op, input logic [3:0] md);
		dstt_pkg::dstt_dec_s r;
		r = '0;
		r.ok = 1'b1;
		if (op == `DSTT_OP_READ) begin
			unique case (md)
				`DSTT_MOD_SEC_CHK:  r.chk = 1'b1;
				`DSTT_MOD_SEC_CCHK: begin
					r.chk = 1'b1;
					r.dir = dstt_pkg::DSTT_DIR_CMP;
				end
				`DSTT_MOD_SEC:      r.dir = dstt_pkg::DSTT_DIR_READ;
				`DSTT_MOD_SEC_CMP:  r.dir = dstt_pkg::DSTT_DIR_CMP;
				`DSTT_MOD_TRK_CHK: begin
					r.chk   = 1'b1;
					r.track = 1'b1;
				end
				`DSTT_MOD_TRK_CCHK: begin
					r.chk   = 1'b1;
					r.track = 1'b1;
					r.dir   = dstt_pkg::DSTT_DIR_CMP;
				end
				`DSTT_MOD_TRK:      r.track = 1'b1;
				`DSTT_MOD_TRK_CMP: begin
					r.track = 1'b1;
					r.dir   = dstt_pkg::DSTT_DIR_CMP;
				end
				default:            r.ok = 1'b0;
			endcase
		end else if (op == `DSTT_OP_WRITE) begin
			r.dir = dstt_pkg::DSTT_DIR_WRITE;
			unique case (md)
				`DSTT_MOD_SEC_CHK: r.chk = 1'b1;
				`DSTT_MOD_SEC:     r.chk = 1'b0;
				`DSTT_MOD_TRK_CHK: begin
					r.chk   = 1'b1;
					r.track = 1'b1;
				end
				`DSTT_MOD_TRK:     r.track = 1'b1;
				default:           r.ok = 1'b0;
			endcase
		end else begin
			r.ok = 1'b0;
		end
		return r;
	endfunction

	// ------------------------------------------------------------------
	// Handshake and mark detection
	// ------------------------------------------------------------------
	// Marks only count in checked variants; unchecked ones pass them as data
	assign dec       = decode(cmd_op, cmd_mod);
	assign take_core = core_rd_valid && q.core_rd_rdy;
	assign take_disk = disk_rd_valid && q.disk_rd_rdy;
	assign gm_core   = q.chk && (core_rd_data == `DSTT_GM_CODE);
	assign gm_disk   = q.chk && (disk_rd_data == `DSTT_GM_CODE);
	assign idx_rise  = q.idx_s2 && !q.idx_s3;
	assign cnt.track   = dec.track;
	assign cnt.sectors = cmd_sectors;

	// Sequencer next state
	always_comb begin
		logic adv;
		adv = 1'b0;
		d = q;
		d.done = 1'b0;
		d.inv = 1'b0;
		d.idx_s1 = disk_index_pin;
		d.idx_s2 = q.idx_s1;
		d.idx_s3 = q.idx_s2;
		cnt.load = 1'b0;
		cnt.step = 1'b0;
		unique case (q.st)
			dstt_pkg::DSTT_ST_IDLE: begin
				if (cmd_valid) begin
					if (!dec.ok) begin
						d.inv = 1'b1;
					end else begin
						cnt.load  = 1'b1;
						d.busy    = 1'b1;
						d.wlr     = 1'b0;
						d.cmp_err = 1'b0;
						d.stop    = 1'b0;
						d.skip    = 1'b0;
						d.dir     = dec.dir;
						d.track   = dec.track;
						d.chk     = dec.chk;
						// Track work waits for the index point
						d.st = dec.track ? dstt_pkg::DSTT_ST_WAIT : dstt_pkg::DSTT_ST_FETCH;
					end
				end
			end
			dstt_pkg::DSTT_ST_WAIT: begin
				if (idx_rise) begin
					d.st = dstt_pkg::DSTT_ST_FETCH;
				end
			end
			dstt_pkg::DSTT_ST_FETCH: begin
				if (q.dir == dstt_pkg::DSTT_DIR_READ) begin
					if (take_disk) begin
						if (q.skip) begin
							adv = 1'b1; // Rest of sector is read but kept out of core
						end else begin
							d.core_wr_vld = 1'b1;
							d.core_wr_dat = disk_rd_data;
							d.st = dstt_pkg::DSTT_ST_EMIT;
							if (gm_disk) begin
								d.wlr  = 1'b1;
								d.stop = 1'b1;
								d.skip = 1'b1;
							end
						end
					end
				end else if (take_core) begin
					if (q.dir == dstt_pkg::DSTT_DIR_WRITE) begin
						if (gm_core && cnt.at_start) begin
							// Record ended on a sector boundary: nothing more goes out
							d.wlr  = 1'b1;
							d.busy = 1'b0;
							d.done = 1'b1;
							d.st   = dstt_pkg::DSTT_ST_IDLE;
						end else begin
							d.disk_wr_vld = 1'b1;
							d.disk_wr_dat = core_rd_data;
							d.st = dstt_pkg::DSTT_ST_EMIT;
							if (gm_core) begin
								d.wlr  = 1'b1;
								d.stop = 1'b1;
							end
						end
					end else begin
						d.hold = core_rd_data;
						d.st   = dstt_pkg::DSTT_ST_FETCHD;
						if (gm_core) begin
							d.wlr  = 1'b1;
							d.stop = 1'b1;
						end
					end
				end
			end
			dstt_pkg::DSTT_ST_FETCHD: begin
				if (take_disk) begin
					adv = 1'b1;
					// Full character compare, marks and fill included
					if (disk_rd_data != q.hold) begin
						d.cmp_err = 1'b1;
					end
					if (gm_disk) begin
						d.wlr  = 1'b1;
						d.stop = 1'b1;
					end
				end
			end
			dstt_pkg::DSTT_ST_EMIT: begin
				if (q.core_wr_vld && core_wr_ready) begin
					d.core_wr_vld = 1'b0;
					adv = 1'b1;
				end
				if (q.disk_wr_vld && disk_wr_ready) begin
					d.disk_wr_vld = 1'b0;
					adv = 1'b1;
				end
			end
			default: d.st = dstt_pkg::DSTT_ST_IDLE;
		endcase
		// A stop requested mid-sector still runs that sector out
		if (adv) begin
			cnt.step = 1'b1;
			if (cnt.last_in_sec && (cnt.last_sec || d.stop)) begin
				d.st   = dstt_pkg::DSTT_ST_IDLE;
				d.busy = 1'b0;
				d.done = 1'b1;
			end else begin
				d.st = dstt_pkg::DSTT_ST_FETCH;
			end
		end
		// Readies registered so they come straight from flops
		d.disk_rd_rdy = (d.st == dstt_pkg::DSTT_ST_FETCHD) ||
			(d.st == dstt_pkg::DSTT_ST_FETCH && d.dir == dstt_pkg::DSTT_DIR_READ);
		d.core_rd_rdy = (d.st == dstt_pkg::DSTT_ST_FETCH) && (d.dir != dstt_pkg::DSTT_DIR_READ);
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign busy          = q.busy;
	assign done          = q.done;
	assign invalid_op    = q.inv;
	assign wrong_length  = q.wlr;
	assign compare_err   = q.cmp_err;
	assign disk_rd_ready = q.disk_rd_rdy;
	assign disk_wr_valid = q.disk_wr_vld;
	assign disk_wr_data  = q.disk_wr_dat;
	assign core_rd_ready = q.core_rd_rdy;
	assign core_wr_valid = q.core_wr_vld;
	assign core_wr_data  = q.core_wr_dat;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	bad_decode_a: assert property (q.st == dstt_pkg::DSTT_ST_IDLE && cmd_valid && !dec.ok
		|=> invalid_op && !busy)
		else $error("invalid combination not refused");
	read_store_a: assert property (q.st == dstt_pkg::DSTT_ST_FETCH && take_disk
		&& !q.skip && q.dir == dstt_pkg::DSTT_DIR_READ
		|=> core_wr_valid && core_wr_data == $past(disk_rd_data))
		else $error("disk character not stored to core");
	write_send_a: assert property (q.st == dstt_pkg::DSTT_ST_FETCH && take_core
		&& q.dir == dstt_pkg::DSTT_DIR_WRITE && !(gm_core && cnt.at_start)
		|=> disk_wr_valid && disk_wr_data == $past(core_rd_data))
		else $error("core character not sent to disk");
	cmp_bits_a: assert property (q.st == dstt_pkg::DSTT_ST_FETCHD && take_disk
		&& disk_rd_data != q.hold |=> compare_err)
		else $error("mismatch not flagged");
	cmp_match_a: assert property (q.st == dstt_pkg::DSTT_ST_IDLE && cmd_valid && dec.ok
		|=> !compare_err && !wrong_length)
		else $error("status not cleared at start");
	index_wait_a: assert property (q.st == dstt_pkg::DSTT_ST_WAIT
		|-> !disk_rd_ready && !core_rd_ready)
		else $error("track transfer began before index");
	index_go_a: assert property (q.st == dstt_pkg::DSTT_ST_WAIT && idx_rise
		|=> q.st == dstt_pkg::DSTT_ST_FETCH)
		else $error("index point did not start track");
	no_check_a: assert property (busy && !q.chk |-> !wrong_length)
		else $error("unchecked variant set wrong length");
	gm_boundary_a: assert property (q.st == dstt_pkg::DSTT_ST_FETCH && take_core
		&& gm_core && cnt.at_start && q.dir == dstt_pkg::DSTT_DIR_WRITE
		|=> done && wrong_length && !disk_wr_valid)
		else $error("boundary mark not handled");
	gm_write_a: assert property (q.st == dstt_pkg::DSTT_ST_FETCH && take_core
		&& gm_core && !cnt.at_start && q.dir == dstt_pkg::DSTT_DIR_WRITE
		|=> disk_wr_valid && disk_wr_data == `DSTT_GM_CODE && wrong_length)
		else $error("odd length mark not written");
	gm_read_a: assert property (q.st == dstt_pkg::DSTT_ST_FETCH && take_disk
		&& gm_disk && !q.skip && q.dir == dstt_pkg::DSTT_DIR_READ
		|=> wrong_length ##1 q.skip)
		else $error("disk mark did not stop read");
	track_full_a: assert property (q.track && q.st == dstt_pkg::DSTT_ST_EMIT && !q.stop
		&& !cnt.last_sec |=> !done)
		else $error("track ended early");

	read_done_c: cover property (q.dir == dstt_pkg::DSTT_DIR_READ && done);
	cmp_fail_c: cover property (compare_err && done);
	boundary_c: cover property (q.dir == dstt_pkg::DSTT_DIR_WRITE && wrong_length && done);
	track_done_c: cover property (q.track && done);
endmodule
`default_nettype wire

// [design/dstt_cfg.svh]
// Constants for the disk sector and track transfer block.
`ifndef DSTT_CFG_SVH
`define DSTT_CFG_SVH

// ----------------------------------------------------------------------
// Operation codes and modifier digits
// ----------------------------------------------------------------------
`define DSTT_OP_READ       8'h36
`define DSTT_OP_WRITE      8'h38
`define DSTT_MOD_SEC_CHK   4'h0
`define DSTT_MOD_SEC_CCHK  4'h1
`define DSTT_MOD_SEC       4'h2
`define DSTT_MOD_SEC_CMP   4'h3
`define DSTT_MOD_TRK_CHK   4'h4
`define DSTT_MOD_TRK_CCHK  4'h5
`define DSTT_MOD_TRK       4'h6
`define DSTT_MOD_TRK_CMP   4'h7

// ----------------------------------------------------------------------
// Geometry and codes
// ----------------------------------------------------------------------
`define DSTT_SEC_CHARS     7'h64
`define DSTT_TRK_CHARS     7'h69
`define DSTT_TRK_SECTORS   12'h014
`define DSTT_GM_CODE       6'h2A
`define DSTT_WLR_IND_NUM   7'h25

`endif

// [design/dstt_pkg.sv]
// Types shared by the disk sector and track transfer modules.
package dstt_pkg;

	typedef enum logic [1:0] {
		DSTT_DIR_READ  = 2'h0,
		DSTT_DIR_WRITE = 2'h1,
		DSTT_DIR_CMP   = 2'h2
	} dstt_dir_e;

	typedef enum logic [2:0] {
		DSTT_ST_IDLE   = 3'h0,
		DSTT_ST_WAIT   = 3'h1,
		DSTT_ST_FETCH  = 3'h2,
		DSTT_ST_FETCHD = 3'h3,
		DSTT_ST_EMIT   = 3'h4
	} dstt_state_e;

	typedef struct packed {
		logic      ok;
		dstt_dir_e dir;
		logic      track;
		logic      chk;
	} dstt_dec_s;

endpackage

// [design/dstt_cnt_if.sv]
// Interface between the transfer sequencer and its position counter.
`timescale 1ns/100ps
`default_nettype none
interface dstt_cnt_if;
	logic        load;
	logic        step;
	logic        track;
	logic [11:0] sectors;
	logic        at_start;
	logic        last_in_sec;
	logic        last_sec;

	modport ctl (output load, output step, output track, output sectors,
		input at_start, input last_in_sec, input last_sec);
	modport cnt (input load, input step, input track, input sectors,
		output at_start, output last_in_sec, output last_sec);
endinterface
`default_nettype wire

// [design/dstt_cnt.sv]
// Character and sector position counter for disk transfers.
`timescale 1ns/100ps
`default_nettype none
`include "dstt_cfg.svh"
module dstt_cnt (
	input  wire logic sys_clk,
	input  wire logic rst,
	dstt_cnt_if.cnt   cnt
);
	typedef struct packed {
		logic [6:0]  pos;
		logic [11:0] sec;
		logic        track;
	} dstt_cnt_s;

	dstt_cnt_s q;
	dstt_cnt_s d;
	logic [6:0] limit;

	// ------------------------------------------------------------------
	// Position decode
	// ------------------------------------------------------------------
	// Track sectors carry five address characters ahead of the data
	assign limit           = q.track ? `DSTT_TRK_CHARS : `DSTT_SEC_CHARS;
	assign cnt.at_start    = (q.pos == 7'h00);
	assign cnt.last_in_sec = (q.pos == limit - 7'h01);
	assign cnt.last_sec    = (q.sec <= 12'h001); // A zero count still moves one sector

	// Next position
	always_comb begin
		d = q;
		if (cnt.load) begin
			d.pos   = 7'h00;
			d.track = cnt.track;
			d.sec   = cnt.track ? `DSTT_TRK_SECTORS : cnt.sectors;
		end else if (cnt.step) begin
			if (cnt.last_in_sec) begin
				d.pos = 7'h00;
				d.sec = q.sec - 12'h001;
			end else begin
				d.pos = q.pos + 7'h01;
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	trk_sectors_a: assert property (cnt.load && cnt.track |=> q.sec == 12'h014)
		else $error("track load did not set twenty sectors");
	sec_wrap_a: assert property (cnt.step && cnt.last_in_sec && !cnt.load
		|=> q.pos == 7'h00 && q.sec == $past(q.sec) - 12'h001)
		else $error("sector end did not wrap position");
endmodule
`default_nettype wire

// [dv/dstt_disk_model.sv]
// Behavioural disk drive: index mark, character source and character sink.
`timescale 1ns/100ps
`default_nettype none
module dstt_disk_model (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       rewind,
	input  wire logic       slow,
	output logic            index_pin,
	output logic            rd_valid,
	output logic [5:0]      rd_data,
	input  wire logic       rd_ready,
	input  wire logic       wr_valid,
	input  wire logic [5:0] wr_data,
	output logic            wr_ready
);
	logic [5:0] mem [0:2200];
	logic [5:0] wmem [0:2200];
	int         rd_ptr;
	int         wr_ptr;
	logic [6:0] rev;
	logic       ph;

	// --------------------------------------------------------------
	// Rotation and streams
	// --------------------------------------------------------------
	// Slow mode offers and accepts only on alternate cycles
	always @(posedge sys_clk) begin
		if (rst || rewind) begin
			rev <= 7'h00;
			ph <= 1'b0;
			index_pin <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= 6'h15;
			wr_ready <= 1'b0;
			rd_ptr <= 0;
			wr_ptr <= 0;
		end else begin
			rev <= rev + 7'h01;
			ph <= ~ph;
			index_pin <= (rev >= 7'h20) && (rev < 7'h24);
			if (rd_valid && rd_ready) begin
				rd_valid <= 1'b0;
				rd_data <= ~rd_data; // Released line shows no stale char
				rd_ptr <= rd_ptr + 1;
			end else if (!rd_valid && (ph || !slow)) begin
				rd_valid <= 1'b1;
				rd_data <= mem[rd_ptr];
			end
			if (wr_ready) begin
				wr_ready <= 1'b0; // One-cycle accept avoids a double take
			end else if (wr_valid && (ph || !slow)) begin
				wr_ready <= 1'b1;
			end
			if (wr_valid && wr_ready) begin
				wmem[wr_ptr] <= wr_data;
				wr_ptr <= wr_ptr + 1;
			end
		end
	end
endmodule
`default_nettype wire

// [dv/dstt_top_tb.sv]
// Self-checking testbench for the disk sector and track transfer block.
`timescale 1ns/100ps
`default_nettype none
module dstt_top_tb;
	logic        sys_clk;
	logic        rst;
	logic        rewind;
	logic        slow;
	logic        cmd_valid;
	logic [7:0]  cmd_op;
	logic [3:0]  cmd_mod;
	logic [11:0] cmd_sectors;
	logic        busy;
	logic        done;
	logic        invalid_op;
	logic        wrong_length;
	logic        compare_err;
	logic        idx;
	logic        d_rv;
	logic [5:0]  d_rd;
	logic        d_rr;
	logic        d_wv;
	logic [5:0]  d_wd;
	logic        d_wr;
	logic        core_rd_valid;
	logic [5:0]  core_rd_data;
	logic        core_rd_ready;
	logic        core_wr_valid;
	logic [5:0]  core_wr_data;
	logic        core_wr_ready;
	logic [5:0]  cmem [0:2200];
	logic [5:0]  cwr [0:2200];
	int          cr_ptr;
	int          cw_ptr;
	int          n_mismatch;
	int          n_tests;

	dstt_top u_dstt_top (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_mod(cmd_mod), .cmd_sectors(cmd_sectors), .busy(busy),
		.done(done), .invalid_op(invalid_op), .wrong_length(wrong_length),
		.compare_err(compare_err), .disk_index_pin(idx), .disk_rd_valid(d_rv),
		.disk_rd_data(d_rd), .disk_rd_ready(d_rr), .disk_wr_valid(d_wv),
		.disk_wr_data(d_wd), .disk_wr_ready(d_wr), .core_rd_valid(core_rd_valid),
		.core_rd_data(core_rd_data), .core_rd_ready(core_rd_ready),
		.core_wr_valid(core_wr_valid), .core_wr_data(core_wr_data),
		.core_wr_ready(core_wr_ready));

	dstt_disk_model u_dstt_disk_model (.sys_clk(sys_clk), .rst(rst), .rewind(rewind),
		.slow(slow), .index_pin(idx), .rd_valid(d_rv), .rd_data(d_rd), .rd_ready(d_rr),
		.wr_valid(d_wv), .wr_data(d_wd), .wr_ready(d_wr));

	// --------------------------------------------------------------
	// Clock and core storage model
	// --------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Core sink stalls every other cycle to exercise the hold rule
	always @(posedge sys_clk) begin
		if (rst || rewind) begin
			cr_ptr <= 0;
			cw_ptr <= 0;
			core_rd_valid <= 1'b0;
			core_rd_data <= cmem[0];
			core_wr_ready <= 1'b0;
		end else begin
			core_rd_valid <= 1'b1;
			core_wr_ready <= ~core_wr_ready;
			if (core_rd_valid && core_rd_ready) begin
				cr_ptr <= cr_ptr + 1;
				core_rd_data <= cmem[cr_ptr + 1];
			end
			if (core_wr_valid && core_wr_ready) begin
				cwr[cw_ptr] <= core_wr_data;
				cw_ptr <= cw_ptr + 1;
			end
		end
	end

	// --------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	// Same pattern on both sides; group marks placed where asked, -1 for none
	task automatic setup(input int gm_disk, input int gm_core);
		for (int i = 0; i <= 2200; i++) begin
			u_dstt_disk_model.mem[i] = 6'(i % 32);
			cmem[i] = 6'(i % 32);
		end
		if (gm_disk >= 0) u_dstt_disk_model.mem[gm_disk] = 6'h2A;
		if (gm_core >= 0) cmem[gm_core] = 6'h2A;
	endtask

	// Issue one command; returns whether it was refused
	task automatic run(input logic [7:0] op, input logic [3:0] md, input logic [11:0] ns,
			output logic inv);
		int k;
		rewind <= 1'b1;
		@(posedge sys_clk);
		rewind <= 1'b0;
		cmd_op <= op;
		cmd_mod <= md;
		cmd_sectors <= ns;
		cmd_valid <= 1'b1;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		@(posedge sys_clk);
		inv = invalid_op;
		k = 0;
		while (inv !== 1'b1 && done !== 1'b1 && k < 12000) begin
			@(posedge sys_clk);
			k++;
		end
		if (inv !== 1'b1) chk("done", done, 1'b1);
		@(posedge sys_clk);
	endtask

	task automatic cmp_core(input int n);
		chk("core_count", cw_ptr, n);
		for (int i = 0; i < n; i++) chk("core_char", cwr[i], u_dstt_disk_model.mem[i]);
	endtask

	task automatic cmp_disk(input int n);
		chk("disk_count", u_dstt_disk_model.wr_ptr, n);
		for (int i = 0; i < n; i++) chk("disk_char", u_dstt_disk_model.wmem[i], cmem[i]);
	endtask

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_checked;
		logic inv;
		setup(-1, 200);
		run(8'h38, 4'h0, 12'h003, inv);
		cmp_disk(200);
		chk("wlr_boundary", wrong_length, 1'b1);
		setup(-1, 85);
		run(8'h38, 4'h0, 12'h001, inv);
		cmp_disk(100);
		chk("wlr_write", wrong_length, 1'b1);
		setup(85, -1);
		run(8'h36, 4'h0, 12'h002, inv);
		cmp_core(86);
		chk("wlr_read", wrong_length, 1'b1);
		setup(300, -1);
		run(8'h36, 4'h4, 12'h014, inv);
		cmp_core(301);
		chk("wlr_track", wrong_length, 1'b1);
		// Checked compare: marks on both sides agree, sector still runs out
		setup(50, 50);
		run(8'h36, 4'h1, 12'h002, inv);
		chk("cmp_chk_len", cr_ptr, 100);
		chk("cmp_chk_eq", compare_err, 1'b0);
		chk("wlr_cmp", wrong_length, 1'b1);
		setup(-1, 400);
		run(8'h36, 4'h5, 12'h014, inv);
		chk("cmp_trk_len", cr_ptr, 420);
		chk("cmp_trk_gm", compare_err, 1'b1);
		chk("wlr_cmp_trk", wrong_length, 1'b1);
		// Checked track write: mark mid-sector is written, sector filled out
		setup(-1, 150);
		run(8'h38, 4'h4, 12'h014, inv);
		cmp_disk(210);
		chk("wlr_wr_trk", wrong_length, 1'b1);
	endtask

	task automatic t_sectors;
		logic inv;
		slow <= 1'b1;
		setup(50, 7);
		run(8'h36, 4'h2, 12'h002, inv);
		cmp_core(200);
		chk("wlr_rd_sec", wrong_length, 1'b0);
		run(8'h38, 4'h2, 12'h001, inv);
		cmp_disk(100);
		chk("wlr_wr_sec", wrong_length, 1'b0);
		setup(20, 20);
		run(8'h36, 4'h3, 12'h001, inv);
		chk("cmp_equal", compare_err, 1'b0);
		u_dstt_disk_model.mem[99] = cmem[99] ^ 6'h20;
		run(8'h36, 4'h3, 12'h001, inv);
		chk("cmp_fill", compare_err, 1'b1);
		chk("wlr_cmp_sec", wrong_length, 1'b0);
		slow <= 1'b0;
	endtask

	task automatic t_tracks;
		logic inv;
		setup(700, 900);
		run(8'h36, 4'h6, 12'h003, inv);
		cmp_core(2100);
		chk("wlr_rd_trk", wrong_length, 1'b0);
		run(8'h38, 4'h6, 12'h001, inv);
		cmp_disk(2100);
		setup(700, 700);
		run(8'h36, 4'h7, 12'h014, inv);
		chk("cmp_trk_eq", compare_err, 1'b0);
		cmem[2099] = cmem[2099] ^ 6'h01;
		run(8'h36, 4'h7, 12'h014, inv);
		chk("cmp_trk_ne", compare_err, 1'b1);
	endtask

	task automatic t_invalid;
		logic [11:0] bad [0:4];
		logic        inv;
		bad = '{12'h381, 12'h383, 12'h387, 12'h372, 12'h368};
		for (int i = 0; i < 5; i++) begin
			run(bad[i][11:4], bad[i][3:0], 12'h001, inv);
			chk("invalid_op", inv, 1'b1);
			chk("busy_refused", busy, 1'b0);
		end
	endtask

	// --------------------------------------------------------------
	// Run control
	// --------------------------------------------------------------
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge sys_clk);
		n_mismatch++;
		wrap_up();
	end

	initial begin
		n_mismatch = 0;
		n_tests = 0;
		rst = 1'b1;
		rewind = 1'b0;
		slow = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 8'h00;
		cmd_mod = 4'h0;
		cmd_sectors = 12'h000;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		t_checked();
		t_sectors();
		t_tracks();
		t_invalid();
		wrap_up();
	end
endmodule
`default_nettype wire
